// ---- rtl/cfg_regs_pkg.sv ----
// Constants for the status, revision, class-code and cache-line-size block.
// Assumes a byte-addressed configuration port on the bus clock.
package cfg_regs_pkg;

  // Register byte offsets
  localparam logic [7:0] bus_status_off         = 8'h06;
  localparam logic [7:0] silicon_revision_off   = 8'h08;
  localparam logic [7:0] function_class_off     = 8'h09;
  localparam logic [7:0] cache_line_length_off  = 8'h0c;

  // Status field positions
  localparam int detected_parity_bit            = 15;
  localparam int signaled_system_error_bit      = 14;
  localparam int master_abort_received_bit      = 13;
  localparam int target_abort_received_bit     = 12;
  localparam int target_abort_signaled_bit      = 11;
  localparam int devsel_timing_lsb              = 9;
  localparam int master_data_parity_bit         = 8;
  localparam int back_to_back_capable_bit       = 7;
  localparam int user_feature_support_bit       = 6;
  localparam int high_speed_capable_bit         = 5;
  localparam int capability_list_present_bit    = 4;

  // Command field positions
  localparam int parity_response_enable_bit     = 6;
  localparam int system_error_enable_bit        = 8;

  // Fixed values and reset values
  localparam logic [1:0]  devsel_medium         = 2'h1;
  localparam logic [15:0] bus_status_reset      = 16'h0210;
  localparam logic [15:0] bus_status_sticky_mask = 16'hf900;
  localparam logic [23:0] function_class_value  = 24'h06_0700;
  localparam logic [7:0]  cache_line_reset      = 8'h00;
  // Arbitrary revision code
  localparam logic [7:0]  silicon_revision_value = 8'h5a;

  // Number of functions, each with its own bus status flags
  localparam int num_functions                  = 2;

endpackage

// ---- rtl/cfg_event_if.sv ----
// Bus events passed from the main block to each per-function flag bank.
// Assumes event and clear strobes are one-cycle pulses on core_clk; flags hold their value.
`timescale 1ns/1ns
interface cfg_event_if;
  logic       parity_detected;
  logic       serr_signaled;
  logic       master_abort;
  logic       target_abort_rx;
  logic       target_abort_tx;
  logic       master_data_parity;
  logic       clear_wr;
  logic [7:0] clear_hi;
  logic [7:0] flags;

  modport source (output parity_detected, serr_signaled, master_abort, target_abort_rx,
                  output target_abort_tx, master_data_parity, clear_wr, clear_hi,
                  input  flags);
  modport sink   (input  parity_detected, serr_signaled, master_abort, target_abort_rx,
                  input  target_abort_tx, master_data_parity, clear_wr, clear_hi,
                  output flags);
endinterface

// ---- rtl/status_flag_bank.sv ----
// One function's copy of the write-one-to-clear status flags.
// Assumes event pulses and clears arrive on core_clk.
`timescale 1ns/1ns
module status_flag_bank
  import cfg_regs_pkg::*;
(
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst,
  // Events and clears
  cfg_event_if.sink   ev
);

  typedef struct packed {
    logic [7:0] flag_q;   // status bits 15..8
  } bank_s;

  bank_s st_q;
  bank_s st_d;

  function automatic logic hold_or_set(input logic cur, input logic set, input logic clr);
    hold_or_set = set | (cur & ~clr);
  endfunction

  always_comb begin
    logic [7:0] set_v;
    logic [7:0] clr_v;
    set_v = 8'h00;
    clr_v = 8'h00;
    set_v[detected_parity_bit - 8]       = ev.parity_detected;
    set_v[signaled_system_error_bit - 8] = ev.serr_signaled;
    set_v[master_abort_received_bit - 8] = ev.master_abort;
    set_v[target_abort_received_bit - 8] = ev.target_abort_rx;
    set_v[target_abort_signaled_bit - 8] = ev.target_abort_tx;
    set_v[master_data_parity_bit - 8]    = ev.master_data_parity;
    clr_v = ev.clear_wr ? (ev.clear_hi & bus_status_sticky_mask[15:8]) : 8'h00;
    st_d = st_q;
    for (int i = 0; i < 8; i++) begin
      st_d.flag_q[i] = hold_or_set(st_q.flag_q[i], set_v[i], clr_v[i]) &
                       bus_status_sticky_mask[i + 8];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= '{flag_q: bus_status_reset[15:8] & bus_status_sticky_mask[15:8]};
    end else begin
      st_q <= st_d;
    end
  end

  // Whole upper status byte, fixed bits already masked to zero
  assign ev.flags = st_q.flag_q;
endmodule

// ---- rtl/cfg_status_regs.sv ----
// Status, revision, class-code and cache-line-size registers for a two-function bridge.
// Assumes single-cycle config strobes with a function number and byte enables.
`timescale 1ns/1ns
module cfg_status_regs
  import cfg_regs_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Configuration access
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_func,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rvalid,
  // Command enables per function
  input  wire logic [15:0] command_f0,
  input  wire logic [15:0] command_f1,
  // Bus events, indexed by function except the shared perr_seen
  input  wire logic [1:0]  addr_parity_err,
  input  wire logic [1:0]  data_parity_err,
  input  wire logic        perr_seen,
  input  wire logic [1:0]  master_of_phase,
  input  wire logic [1:0]  master_abort_evt,
  input  wire logic [1:0]  target_abort_rx_evt,
  input  wire logic [1:0]  target_abort_tx_evt,
  input  wire logic [1:0]  serr_request,
  // Bus-side reporting
  output logic             serr_assert,
  output logic             perr_assert
);

  typedef struct packed {
    logic [1:0][7:0] cache_q;
    logic [31:0]     rdata_q;
    logic            rvalid_q;
    logic            serr_q;
    logic            perr_q;
  } regs_s;

  regs_s st_q;
  regs_s st_d;

  logic [1:0][15:0] cmd;
  wire  logic [1:0][7:0] flags;
  wire  logic [1:0]      serr_fire;
  wire  logic [1:0]      perr_fire;

  assign cmd[0] = command_f0;
  assign cmd[1] = command_f1;

  function automatic logic [3:0] word_lane(input logic [7:0] a, input logic [7:0] off);
    word_lane = (a[7:2] == off[7:2]) ? (4'h1 << off[1:0]) : 4'h0;
  endfunction

  // Per-function flag banks fed from per-function bus events
  genvar g;
  generate
    for (g = 0; g < num_functions; g++) begin : gen_fn
      cfg_event_if ev ();
      logic prm;
      logic sen;
      assign prm = cmd[g][parity_response_enable_bit];
      assign sen = cmd[g][system_error_enable_bit];
      // Data parity answered with PERR only when parity response is on
      assign perr_fire[g] = data_parity_err[g] & prm;
      // Address parity answered with SERR only when both enables set
      assign serr_fire[g] = sen & ((addr_parity_err[g] & prm) | serr_request[g]);
      assign ev.parity_detected    = addr_parity_err[g] | data_parity_err[g];
      assign ev.serr_signaled      = serr_fire[g];
      assign ev.master_abort       = master_abort_evt[g];
      assign ev.target_abort_rx    = target_abort_rx_evt[g];
      assign ev.target_abort_tx    = target_abort_tx_evt[g];
      assign ev.master_data_parity = perr_seen & master_of_phase[g] & prm;
      assign ev.clear_wr = cfg_wr & (cfg_func == 1'(g)) &
                           (cfg_addr[7:2] == bus_status_off[7:2]);
      assign ev.clear_hi = cfg_wdata[31:24];
      assign flags[g]    = ev.flags;
      status_flag_bank u_bank (
        .core_clk (core_clk),
        .rst      (rst),
        .ev       (ev)
      );
    end
  endgenerate

  function automatic logic [15:0] status_word(input logic [7:0] f);
    logic [15:0] s;
    s = 16'h0000;
    s[15:8] = f & bus_status_sticky_mask[15:8];
    s[devsel_timing_lsb +: 2]         = devsel_medium;
    s[back_to_back_capable_bit]       = 1'b0;
    s[user_feature_support_bit]       = 1'b0;
    s[high_speed_capable_bit]         = 1'b0;
    s[capability_list_present_bit]    = 1'b1;
    return s;
  endfunction

  always_comb begin
    logic [15:0] sw;
    logic [3:0]  cl_lane;
    logic [7:0]  cl;
    sw      = status_word(flags[cfg_func]);
    cl      = st_q.cache_q[cfg_func];
    cl_lane = word_lane(cfg_addr, cache_line_length_off);
    st_d = st_q;
    st_d.rvalid_q = cfg_rd;
    st_d.rdata_q  = 32'h0000_0000;
    if (cfg_rd) begin
      case (cfg_addr[7:2])
        bus_status_off[7:2]: st_d.rdata_q = {sw, 16'h0000};
        silicon_revision_off[7:2]: begin
          st_d.rdata_q = {function_class_value, silicon_revision_value};
        end
        cache_line_length_off[7:2]: st_d.rdata_q = {24'h00_0000, cl};
        default: st_d.rdata_q = 32'h0000_0000;
      endcase
    end
    if (cfg_wr && (cl_lane & cfg_be) != 4'h0) begin
      st_d.cache_q[cfg_func] = cfg_wdata[7:0];
    end
    st_d.serr_q = |serr_fire;
    st_d.perr_q = |perr_fire;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q.cache_q  <= {cache_line_reset, cache_line_reset};
      st_q.rdata_q  <= 32'h0000_0000;
      st_q.rvalid_q <= 1'b0;
      st_q.serr_q   <= 1'b0;
      st_q.perr_q   <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg_rdata   = st_q.rdata_q;
  assign cfg_rvalid  = st_q.rvalid_q;
  assign serr_assert = st_q.serr_q;
  assign perr_assert = st_q.perr_q;
endmodule

// ---- bench/cfg_status_regs_monitor.sv ----
// Port-level assertions for the configuration status block.
// Assumes the hand-over timing: reads answer one cycle after the strobe.
`timescale 1ns/1ns
module cfg_status_regs_monitor
  import cfg_regs_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Configuration access
  input wire logic        cfg_rd,
  input wire logic        cfg_func,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_rvalid,
  // Events and reporting
  input wire logic [15:0] command_f0,
  input wire logic [1:0]  data_parity_err,
  input wire logic [1:0]  master_abort_evt,
  input wire logic [1:0]  serr_request,
  input wire logic        serr_assert,
  input wire logic        perr_assert
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_read_answer:
    assert property (cfg_rvalid == $past(cfg_rd))
    else $error("read answer off by a cycle");
  a_idle_zero:
    assert property (!cfg_rvalid |-> cfg_rdata == 32'h0000_0000)
    else $error("read data not zero when idle");
  a_devsel_timing:
    assert property (cfg_rd && cfg_addr[7:2] == 6'h01 |=> cfg_rdata[26:25] == devsel_medium)
    else $error("decode timing field wrong");
  a_fixed_caps:
    assert property (cfg_rd && cfg_addr[7:2] == 6'h01 |=> cfg_rdata[23:16] == 8'h10)
    else $error("fixed status bits wrong");
  a_class_code:
    assert property (cfg_rd && cfg_addr[7:2] == 6'h02 |=>
      cfg_rdata == {function_class_value, silicon_revision_value})
    else $error("class or revision wrong");
  a_parity_seen:
    assert property (data_parity_err[0] ##1 (cfg_rd && cfg_addr[7:2] == 6'h01 && !cfg_func)
      |=> cfg_rdata[31])
    else $error("parity flag not set");
  a_abort_seen:
    assert property (master_abort_evt[1] ##1 (cfg_rd && cfg_addr[7:2] == 6'h01 && cfg_func)
      |=> cfg_rdata[29])
    else $error("master abort flag not set");
  a_serr_report:
    assert property (serr_request[0] && command_f0[8] |=> serr_assert)
    else $error("system error not reported");
  a_perr_report:
    assert property (data_parity_err[0] && command_f0[6] |=> perr_assert)
    else $error("parity error not reported");
  a_perr_quiet:
    assert property (!data_parity_err[0] && !data_parity_err[1] |=> !perr_assert)
    else $error("parity error reported without cause");
endmodule
bind cfg_status_regs cfg_status_regs_monitor mon (.core_clk(core_clk), .rst(rst),
  .cfg_rd(cfg_rd), .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
  .cfg_rvalid(cfg_rvalid), .command_f0(command_f0), .data_parity_err(data_parity_err),
  .master_abort_evt(master_abort_evt), .serr_request(serr_request),
  .serr_assert(serr_assert), .perr_assert(perr_assert));

// ---- bench/config_host.sv ----
// Host side: single configuration reads and writes.
// Assumes one access at a time, launched on falling edges.
`timescale 1ns/1ns
module config_host (
  // Clock
  input  wire logic        core_clk,
  // Request
  output logic             cfg_rd,
  output logic             cfg_wr,
  output logic             cfg_func,
  output logic      [7:0]  cfg_addr,
  output logic      [3:0]  cfg_be,
  output logic      [31:0] cfg_wdata,
  // Answer
  input  wire logic [31:0] cfg_rdata
);
  initial begin
    {cfg_rd, cfg_wr, cfg_func, cfg_addr, cfg_be, cfg_wdata} = '0;
  end
  // One strobe cycle; strobes drop to zero, other released lines turn to their inverse
  // Read data stands for the cycle after the strobe edge; taken before release
  task automatic go(input logic r, w, f, input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d, output logic [31:0] q);
    @(negedge core_clk);
    {cfg_rd, cfg_wr, cfg_func, cfg_addr, cfg_be, cfg_wdata} = {r, w, f, a, be, d};
    @(negedge core_clk);
    q = cfg_rdata;
    {cfg_rd, cfg_wr} = 2'b00;
    {cfg_func, cfg_addr, cfg_be, cfg_wdata} = ~{f, a, be, d};
  endtask
  task automatic wr(input logic f, input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    logic [31:0] unused_q;
    go(1'b0, 1'b1, f, a, be, d, unused_q);
  endtask
  task automatic rd(input logic f, input logic [7:0] a, output logic [31:0] d);
    go(1'b1, 1'b0, f, a, 4'h0, 32'h0000_0000, d);
  endtask
endmodule

// ---- bench/test_cfg_status_regs.sv ----
// Self-checking bench for the configuration status registers.
// Assumes config_host for accesses and the bound monitor.
`timescale 1ns/1ns
module test_cfg_status_regs
  import cfg_regs_pkg::*;
;
  localparam logic [31:0] idle_st = {bus_status_reset, 16'h0000};
  logic        core_clk, rst, cfg_rd, cfg_wr, cfg_func, cfg_rvalid, serr_assert, perr_assert;
  logic [15:0] cmd;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, got;
  logic [6:0]  evp;
  logic        fsel;
  wire  [1:0]  fv = {fsel, !fsel};
  int          fail_count, comparisons, cycles;
  // Per step: event source, command value, expected status
  int          ev_src [9] = '{0, 1, 2, 3, 4, 5, 4, 6, 5};
  logic [15:0] ev_cmd [9] = '{16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0100,
                              16'h0040, 16'h0000, 16'h0140, 16'h0000};
  logic [15:0] ev_exp [9] = '{16'h8210, 16'h2210, 16'h1210, 16'h0a10, 16'h4210,
                              16'h0310, 16'h0210, 16'hc210, 16'h0210};
  cfg_status_regs dut (.core_clk(core_clk), .rst(rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .command_f0(fsel ? 16'h0000 : cmd),
    .command_f1(fsel ? cmd : 16'h0000), .data_parity_err(evp[0] ? fv : 2'b00),
    .master_abort_evt(evp[1] ? fv : 2'b00), .target_abort_rx_evt(evp[2] ? fv : 2'b00),
    .target_abort_tx_evt(evp[3] ? fv : 2'b00), .serr_request(evp[4] ? fv : 2'b00),
    .perr_seen(evp[5]), .master_of_phase(evp[5] ? fv : 2'b00),
    .addr_parity_err(evp[6] ? fv : 2'b00), .serr_assert(serr_assert),
    .perr_assert(perr_assert));
  config_host host (.core_clk(core_clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_func(cfg_func), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic rdchk(input logic f, input logic [7:0] a, input logic [31:0] exp);
    host.rd(f, a, got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle event pulse on the chosen function
  task automatic pulse(input int k);
    @(negedge core_clk);
    fsel = k[0];
    cmd = ev_cmd[k];
    evp = 7'h01 << ev_src[k];
    fork
      @(negedge core_clk) evp = 7'h00;
    join_none
  endtask
  initial begin
    rst = 1'b1;
    fsel = 1'b0;
    cmd = 16'h0000;
    evp = 7'h00;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    for (int f = 0; f < 2; f++) begin
      rdchk(f[0], bus_status_off, idle_st);
      rdchk(f[0], function_class_off, {function_class_value, silicon_revision_value});
    end
    host.wr(1'b0, silicon_revision_off, 4'hf, 32'hffff_ffff);
    rdchk(1'b0, silicon_revision_off, {function_class_value, silicon_revision_value});
    rdchk(1'b0, cache_line_length_off, 32'h0000_0000);
    host.wr(1'b0, cache_line_length_off, 4'h1, 32'h0000_0040);
    host.wr(1'b0, cache_line_length_off, 4'he, 32'h0000_0077);
    rdchk(1'b0, cache_line_length_off, 32'h0000_0040);
    rdchk(1'b0, 8'h10, 32'h0000_0000);
    for (int k = 0; k < 9; k++) begin
      pulse(k);
      rdchk(k[0], bus_status_off, {ev_exp[k], 16'h0000});
      rdchk(!k[0], bus_status_off, idle_st);
      host.wr(k[0], bus_status_off, 4'hc, 32'h0000_0000);
      rdchk(k[0], bus_status_off, {ev_exp[k], 16'h0000});
      host.wr(k[0], bus_status_off, 4'hc, 32'hffff_0000);
      rdchk(k[0], bus_status_off, idle_st);
    end
    final_report();
  end
endmodule
